// file: rtl/sfcr_pkg.sv
// sfcr_pkg: shared constants and types of the serial flash read front end.
// assumes one system clock of 125 MHz and a slower serial link sampled on it.
package sfcr_pkg;

  // opcodes of the two continuous array reads served here
  localparam logic [7:0] OP_READ_LEGACY = 8'he8;
  localparam logic [7:0] OP_READ_FASTEST = 8'h1b;

  // frame layout, counted in serial clock rising edges
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_BITS_LEGACY = 32;
  localparam int DUMMY_BITS_FASTEST = 16;
  localparam logic [6:0] FRAME_BITS_LEGACY = 7'h40;
  localparam logic [6:0] FRAME_BITS_FASTEST = 7'h30;

  // address field positions within the 24 transmitted bits
  localparam int PAGE_BITS = 12;
  localparam int BYTE_BITS = 10;
  localparam int STD_PAGE_LSB = 10;
  localparam int BIN_PAGE_LSB = 9;
  localparam logic [9:0] STD_BYTE_MASK = 10'h3ff;
  localparam logic [9:0] BIN_BYTE_MASK = 10'h1ff;

  // last byte of a page for each page size, and last page of the array
  localparam logic [9:0] PAGE_LAST_STD = 10'h20f;
  localparam logic [9:0] PAGE_LAST_BIN = 10'h1ff;
  localparam logic [11:0] PAGE_LAST_INDEX = 12'hfff;

  // prefetch buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

  // reset values of the pin synchronisers (deselected, clock low)
  localparam logic CS_RESET = 1'b1;
  localparam logic SCK_RESET = 1'b0;

  // link timing, the bench runs the serial clock at this period
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_PERIOD_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;

  // frame sequencer states
  typedef enum logic [2:0] {
    SFCR_IDLE = 3'b000,
    SFCR_OPCODE = 3'b001,
    SFCR_ADDR = 3'b010,
    SFCR_DUMMY = 3'b011,
    SFCR_DATA = 3'b100,
    SFCR_IGNORE = 3'b101
  } sfcr_state_type;

endpackage : sfcr_pkg

// file: rtl/sfcr_fifo.sv
// sfcr_fifo: small flip-flop fifo with valid/ready on both sides.
// assumes a single clock; flush empties it and wins over a push.
module sfcr_fifo #(
  parameter int WIDTH = sfcr_pkg::FIFO_WIDTH,
  parameter int DEPTH = sfcr_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer wrap relies on a power of two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("sfcr_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_width_check
    $error("sfcr_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] store [DEPTH]; // entries, indexed by pointer
  logic [PW-1:0] wr_ptr; // next slot to fill
  logic [PW-1:0] rd_ptr; // oldest entry
  logic [PW:0] count; // entries held
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign in_ready = (count != DEPTH[PW:0]);
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : sfcr_fifo

// file: rtl/sfcr_core.sv
// sfcr_core: serial front end serving continuous main-array reads.
// assumes the link pins are asynchronous to clk and toggle well below
// a quarter of its rate; the array answers one byte request at a time.
//
// Contract
// (R1) chip select fall starts opcode then address
// (R2) every byte travels most significant bit first
// (R3) three address bytes, dummy bits plus address
// (R4) standard pages: ten-bit buffer byte address
// (R5) standard pages: twelve page, ten byte bits
// (R6) binary pages: nine-bit buffer byte address
// (R7) binary pages: bits 20..9 page, 8..0 byte
// (R8) opcode selects main array or buffer source; here buffer read opcodes are ignored
// (R9) serial modes 0 and 3 both accepted
// (R10) legacy read: opcode, address, four dummy bytes
// (R11) fastest read: opcode, address, two dummy bytes
// (R12) internal address counter advances while streaming
// (R13) page end continues into next page seamlessly
// (R14) array end wraps to first page seamlessly
// (R15) host keeps chip select low whole read
// (R16) chip select rise ends read, output off
// (R17) continuous reads bypass and preserve both buffers
// (R18) host should avoid the legacy read opcode
// (R19) sample on rising edge, drive on falling
// (R20) reset low aborts and holds sequencer idle
// (R21) real address bits right-aligned, leading bits ignored
// (R22) first data bit on fall after last dummy
module sfcr_core #(
  parameter int FIFO_DEPTH = sfcr_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link pins
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // configuration, same clock domain
  input wire logic page_binary,
  // main array read port
  output logic mem_rd,
  output logic [11:0] mem_page,
  output logic [9:0] mem_byte,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  // status
  output logic stream_active,
  output logic underrun
);

  if (FIFO_DEPTH < 2) begin : g_param_check
    $error("sfcr_core: FIFO_DEPTH must be at least 2");
  end

  // last byte of a page for the configured size
  function automatic logic [9:0] page_last(input logic bin);
    return bin ? sfcr_pkg::PAGE_LAST_BIN : sfcr_pkg::PAGE_LAST_STD;
  endfunction : page_last

  // pin synchronisers; stage one feeds only stage two
  logic cs_s1, cs_s2, cs_prev;
  logic sck_s1, sck_s2, sck_prev;
  logic si_s1, si_s2;
  logic sck_rise; // one-cycle enable per rising link edge
  logic sck_fall; // one-cycle enable per falling link edge
  logic cs_fall;
  logic [1:0] cs_settle; // counts out the synchroniser after reset
  logic cs_armed; // chip select seen high since reset

  sfcr_pkg::sfcr_state_type state; // frame sequencer
  logic [5:0] bit_cnt; // bits within the current phase
  logic [5:0] phase_last; // last bit index of the phase
  logic phase_end;
  logic [23:0] shift_in; // incoming bits, newest at bit 0
  logic [23:0] next_shift;
  logic [7:0] opcode; // captured instruction
  logic op_ok; // opcode is a served read

  logic fetch_on; // prefetch enabled for this frame
  logic pending; // one array request outstanding
  logic drop; // discard a reply that outlived its frame
  logic [11:0] fetch_page;
  logic [9:0] fetch_byte;

  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;
  logic [7:0] out_sh; // remaining bits of the byte on the pin
  logic [2:0] out_cnt; // bit of the byte going out next
  logic [6:0] rise_cnt; // rising edges in frame, for checks

  // two-stage capture of the asynchronous pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1 <= sfcr_pkg::CS_RESET;
      cs_s2 <= sfcr_pkg::CS_RESET;
      cs_prev <= sfcr_pkg::CS_RESET;
      sck_s1 <= sfcr_pkg::SCK_RESET;
      sck_s2 <= sfcr_pkg::SCK_RESET;
      sck_prev <= sfcr_pkg::SCK_RESET;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
      cs_settle <= 2'h0;
      cs_armed <= 1'b0;
    end else begin
      // stage two holds its reset value for two cycles; wait it out
      cs_settle <= {cs_settle[0], 1'b1};
      cs_armed <= cs_armed || (cs_settle[1] && cs_s2); // R20
      cs_s1 <= cs_b;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_prev <= sck_s2;
      si_s1 <= si;
      si_s2 <= si_s1;
    end
  end

  // edge enables, only while selected
  assign sck_rise = sck_s2 && !sck_prev && !cs_s2; // R19
  assign sck_fall = !sck_s2 && sck_prev && !cs_s2; // R19
  // no false frame start when reset lifts with select already low
  assign cs_fall = cs_prev && !cs_s2 && cs_armed; // R1 R20

  // opcode, address and dummy bits shift in msb first
  assign next_shift = {shift_in[22:0], si_s2}; // R2
  assign op_ok = (next_shift[7:0] == sfcr_pkg::OP_READ_LEGACY) ||
                 (next_shift[7:0] == sfcr_pkg::OP_READ_FASTEST); // R8

  // length of each phase in bits, minus one
  always_comb begin
    phase_last = 6'h3f;
    unique case (state)
      sfcr_pkg::SFCR_OPCODE:
        phase_last = 6'(sfcr_pkg::OPCODE_BITS - 1); // R1
      sfcr_pkg::SFCR_ADDR:
        phase_last = 6'(sfcr_pkg::ADDR_BITS - 1); // R3
      sfcr_pkg::SFCR_DUMMY: begin
        // legacy read waits four dummy bytes, fastest two
        if (opcode == sfcr_pkg::OP_READ_LEGACY) begin
          phase_last = 6'(sfcr_pkg::DUMMY_BITS_LEGACY - 1); // R10
        end else begin
          phase_last = 6'(sfcr_pkg::DUMMY_BITS_FASTEST - 1); // R11
        end
      end
      sfcr_pkg::SFCR_IDLE, sfcr_pkg::SFCR_DATA, sfcr_pkg::SFCR_IGNORE:
        phase_last = 6'h3f;
      default: phase_last = 6'h3f;
    endcase
  end
  assign phase_end = sck_rise && (bit_cnt == phase_last);

  // frame sequencer; chip select high forces idle from any state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sfcr_pkg::SFCR_IDLE; // R20
    end else if (cs_s2) begin
      state <= sfcr_pkg::SFCR_IDLE; // R16
    end else begin
      unique case (state)
        sfcr_pkg::SFCR_IDLE: begin
          // only a fresh select starts a frame, not a reset release
          if (cs_fall) begin
            state <= sfcr_pkg::SFCR_OPCODE; // R1
          end
        end
        sfcr_pkg::SFCR_OPCODE: begin
          if (phase_end) begin
            // buffer reads and all other opcodes are not served here
            state <= op_ok ? sfcr_pkg::SFCR_ADDR
                           : sfcr_pkg::SFCR_IGNORE; // R8
          end
        end
        sfcr_pkg::SFCR_ADDR: begin
          if (phase_end) begin
            state <= sfcr_pkg::SFCR_DUMMY; // R3
          end
        end
        sfcr_pkg::SFCR_DUMMY: begin
          if (phase_end) begin
            state <= sfcr_pkg::SFCR_DATA; // R22
          end
        end
        sfcr_pkg::SFCR_DATA, sfcr_pkg::SFCR_IGNORE: begin
          // stays until deselect; the host holds select low meanwhile
          state <= state; // R15
        end
        default: state <= sfcr_pkg::SFCR_IDLE;
      endcase
    end
  end

  // phase bit counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= '0;
    end else if (cs_s2 || state == sfcr_pkg::SFCR_IDLE) begin
      bit_cnt <= '0;
    end else if (phase_end) begin
      bit_cnt <= '0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // input shifter and opcode capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_in <= '0;
      opcode <= '0;
    end else if (sck_rise) begin
      shift_in <= next_shift;
      if (state == sfcr_pkg::SFCR_OPCODE && phase_end) begin
        opcode <= next_shift[7:0]; // R1
      end
    end
  end

  // fetch address: loaded at address end, then advanced per request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_page <= '0;
      fetch_byte <= '0;
    end else if (state == sfcr_pkg::SFCR_ADDR && phase_end) begin
      // leading address bits beyond the page field are ignored
      if (page_binary) begin
        fetch_page <= next_shift[sfcr_pkg::BIN_PAGE_LSB +:
                                 sfcr_pkg::PAGE_BITS]; // R7 R21
        fetch_byte <= next_shift[9:0] & sfcr_pkg::BIN_BYTE_MASK; // R6
      end else begin
        fetch_page <= next_shift[sfcr_pkg::STD_PAGE_LSB +:
                                 sfcr_pkg::PAGE_BITS]; // R5 R21
        fetch_byte <= next_shift[9:0] & sfcr_pkg::STD_BYTE_MASK; // R4
      end
    end else if (mem_rd) begin
      // offsets past the page end also roll into the next page
      if (fetch_byte >= page_last(page_binary)) begin
        fetch_byte <= '0; // R13
        fetch_page <= fetch_page + 12'h001; // R13 R14
      end else begin
        fetch_byte <= fetch_byte + 10'h001; // R12
      end
    end
  end

  // prefetch straight from the array; the buffers are never touched
  assign mem_rd = fetch_on && !pending && fifo_in_ready && !cs_s2; // R17
  assign mem_page = fetch_page;
  assign mem_byte = fetch_byte;

  // request bookkeeping; one outstanding keeps a fifo slot reserved
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_on <= 1'b0;
      pending <= 1'b0;
      drop <= 1'b0;
    end else begin
      if (cs_s2) begin
        fetch_on <= 1'b0; // R16
      end else if (state == sfcr_pkg::SFCR_ADDR && phase_end) begin
        fetch_on <= 1'b1; // R12
      end
      if (mem_rd) begin
        pending <= 1'b1;
      end else if (mem_rvalid) begin
        pending <= 1'b0;
      end
      // a reply still in flight at deselect belongs to no frame
      if (mem_rvalid) begin
        drop <= 1'b0;
      end else if (cs_s2 && pending) begin
        drop <= 1'b1;
      end
    end
  end

  // prefetch buffer between array and serial output
  sfcr_fifo #(
    .WIDTH(sfcr_pkg::FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .flush(cs_s2),
    .in_valid(mem_rvalid && !drop),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // a new byte is taken at the falling edge that starts it
  assign fifo_pop = sck_fall && (state == sfcr_pkg::SFCR_DATA) &&
                    (out_cnt == 3'h0);

  // output shifter, driven on falling link edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      so <= 1'b0;
      out_sh <= '0;
      out_cnt <= '0;
    end else if (state != sfcr_pkg::SFCR_DATA) begin
      out_cnt <= '0;
    end else if (sck_fall) begin
      if (out_cnt == 3'h0) begin
        if (fifo_out_valid) begin
          so <= fifo_out_data[7]; // R2 R22
          out_sh <= {fifo_out_data[6:0], 1'b0};
          out_cnt <= 3'h1;
        end else begin
          // array too slow: hold position rather than skip a byte
          so <= 1'b0;
        end
      end else begin
        so <= out_sh[7]; // R19
        out_sh <= {out_sh[6:0], 1'b0};
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  // pin is driven only while streaming
  assign so_oe = (state == sfcr_pkg::SFCR_DATA); // R16
  assign stream_active = so_oe;

  // underrun flag, held until the next frame starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      underrun <= 1'b0;
    end else if (cs_fall) begin
      underrun <= 1'b0;
    end else if (fifo_pop && !fifo_out_valid) begin
      underrun <= 1'b1;
    end
  end

  // rising edge count per frame, read only by checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_cnt <= '0;
    end else if (state == sfcr_pkg::SFCR_IDLE) begin
      rise_cnt <= '0;
    end else if (sck_rise && rise_cnt != 7'h7f) begin
      rise_cnt <= rise_cnt + 7'h01;
    end
  end

  // checks on the frame sequence
  AST_DESELECT_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    cs_s2 |=> !so_oe && !fetch_on) // R16
    else $error("output still driven after deselect");

  AST_OPCODE_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    (state == sfcr_pkg::SFCR_OPCODE) && sck_rise && bit_cnt == 6'h07
    && !cs_s2 |=> state != sfcr_pkg::SFCR_OPCODE) // R1
    else $error("opcode phase not eight bits");

  AST_LEGACY_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state == sfcr_pkg::SFCR_DATA) &&
    opcode == sfcr_pkg::OP_READ_LEGACY
    |-> rise_cnt == sfcr_pkg::FRAME_BITS_LEGACY) // R10
    else $error("legacy read header length wrong");

  AST_FAST_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state == sfcr_pkg::SFCR_DATA) &&
    opcode == sfcr_pkg::OP_READ_FASTEST
    |-> rise_cnt == sfcr_pkg::FRAME_BITS_FASTEST) // R11
    else $error("fastest read header length wrong");

  AST_FIRST_BIT: assert property (@(posedge clk) disable iff (!rst_b)
    fifo_pop && fifo_out_valid |=> so == $past(fifo_out_data[7])
    && out_cnt == 3'h1) // R22
    else $error("first bit of byte is not its msb");

  AST_ADDR_STD: assert property (@(posedge clk) disable iff (!rst_b)
    state == sfcr_pkg::SFCR_ADDR && phase_end && !cs_s2 && !page_binary
    |=> fetch_page == $past(next_shift[21:10])
    && fetch_byte == $past(next_shift[9:0])) // R5
    else $error("standard page address split wrong");

  AST_ADDR_BIN: assert property (@(posedge clk) disable iff (!rst_b)
    state == sfcr_pkg::SFCR_ADDR && phase_end && !cs_s2 && page_binary
    |=> fetch_page == $past(next_shift[20:9])
    && fetch_byte == {1'b0, $past(next_shift[8:0])}) // R7
    else $error("binary page address split wrong");

  AST_INCREMENT: assert property (@(posedge clk) disable iff (!rst_b)
    mem_rd && fetch_byte < page_last(page_binary)
    |=> fetch_byte == $past(fetch_byte) + 10'h001
    && fetch_page == $past(fetch_page)) // R12
    else $error("address counter did not advance");

  AST_PAGE_CROSS: assert property (@(posedge clk) disable iff (!rst_b)
    mem_rd && fetch_byte == page_last(page_binary)
    |=> fetch_byte == 10'h000
    && fetch_page == $past(fetch_page) + 12'h001) // R13 R14
    else $error("page crossover wrong");

  AST_ARRAY_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    mem_rd && fetch_page == sfcr_pkg::PAGE_LAST_INDEX &&
    fetch_byte == page_last(page_binary)
    |=> fetch_page == 12'h000) // R14
    else $error("array end did not wrap to first page");

  COV_LEGACY: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(state == sfcr_pkg::SFCR_DATA) &&
    opcode == sfcr_pkg::OP_READ_LEGACY);
  COV_FASTEST: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(state == sfcr_pkg::SFCR_DATA) &&
    opcode == sfcr_pkg::OP_READ_FASTEST);
  COV_CROSS: cover property (@(posedge clk) disable iff (!rst_b)
    mem_rd && fetch_byte == page_last(page_binary));
  COV_ABORT: cover property (@(posedge clk) disable iff (!rst_b)
    state == sfcr_pkg::SFCR_DATA ##1 state == sfcr_pkg::SFCR_IDLE);

endmodule : sfcr_core

// file: tb/sfcr_array_model.sv
// sfcr_array_model: behavioural main array behind the read port.
// assumes one request outstanding at a time, latency set by lat.
module sfcr_array_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // read port
  input wire logic mem_rd,
  input wire logic [11:0] mem_page,
  input wire logic [9:0] mem_byte,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata,
  // extra wait cycles before a reply
  input wire logic [7:0] lat
);
  timeunit 1ns;
  timeprecision 100ps;

  logic busy; // a request is in flight
  logic [7:0] cnt; // cycles left to wait
  logic [7:0] held; // byte fetched for the reply

  // reply after lat+1 cycles; data toggles outside replies so a stale
  // byte can never pass for a fresh one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      held <= 8'h00;
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd) begin
        busy <= 1'b1;
        cnt <= lat;
        held <= mem_page[7:0] ^ mem_byte[7:0] ^ {6'h00, mem_byte[9:8]};
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= held;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : sfcr_array_model

// file: tb/tb_sfcr_core.sv
// tb_sfcr_core: self-checking bench acting as the serial host.
// assumes the array model answers the read port; link runs at 160 ns.
module tb_sfcr_core;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_b, cs_b, sck, si, so, so_oe, page_binary; // link and config
  logic mem_rd, mem_rvalid, stream_active, underrun; // array and status
  logic [11:0] mem_page;
  logic [9:0] mem_byte;
  logic [7:0] mem_rdata, lat, shreg;
  logic mode3; // serial clock idles high when set
  logic [7:0] exp_q[$]; // expected bytes, oldest first
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int nbit;

  sfcr_core #(.FIFO_DEPTH(4)) i_sfcr_core (.clk(clk), .rst_b(rst_b),
    .cs_b(cs_b), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .page_binary(page_binary), .mem_rd(mem_rd), .mem_page(mem_page),
    .mem_byte(mem_byte), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .stream_active(stream_active), .underrun(underrun));
  sfcr_array_model i_sfcr_array_model (.clk(clk), .rst_b(rst_b),
    .mem_rd(mem_rd), .mem_page(mem_page), .mem_byte(mem_byte),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .lat(lat));

  // system clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // hang guard, well above the roughly 17k cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      end_sim();
    end
  end

  // half a link period, drives land just after a clk edge
  task automatic half;
    repeat (10) @(posedge clk);
    #1;
  endtask : half

  // one link bit: fall, new data, rise
  task automatic bit_out(input logic b);
    sck = 1'b0;
    si = b;
    half();
    sck = 1'b1;
    half();
  endtask : bit_out

  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bit_out(v[i]);
  endtask : shift

  // whole frame; nb full data bytes expected, extra bits clocked beyond
  task automatic frame(input logic [7:0] op, input logic [11:0] pg,
                       input logic [9:0] by, input int nb, input int extra);
    logic [23:0] a;
    int last;
    int dum;
    // junk leading bits must be ignored
    a = page_binary ? {3'h7, pg, by[8:0]} : {2'h3, pg, by};
    last = page_binary ? 511 : 527;
    dum = (op == sfcr_pkg::OP_READ_LEGACY) ? sfcr_pkg::DUMMY_BITS_LEGACY
                                          : sfcr_pkg::DUMMY_BITS_FASTEST;
    for (int k = 0; k < nb; k++) begin
      exp_q.push_back(pg[7:0] ^ by[7:0] ^ {6'h00, by[9:8]});
      if (by == last[9:0]) begin
        by = 10'h000;
        pg = pg + 12'h001;
      end else begin
        by = by + 10'h001;
      end
    end
    sck = mode3;
    half();
    cs_b = 1'b0;
    half();
    shift({24'h0, op}, 8);
    shift({8'h0, a}, 24);
    shift(32'h0, dum);
    for (int k = 0; k < nb * 8 + extra; k++) bit_out(1'b0);
    if (!mode3) begin
      sck = 1'b0;
      half();
    end
    cs_b = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({11'h0, so_oe}, 12'h000);
    chk({11'h0, stream_active}, 12'h000);
    chk({11'h0, underrun}, 12'h000);
    chk(exp_q.size(), 12'h000);
  endtask : frame

  // watcher: shifts in one so bit at each rise while driving, checks each byte
  initial begin
    nbit = 0;
    forever begin
      @(posedge sck);
      if (so_oe !== 1'b1) begin
        nbit = 0;
      end else begin
        shreg = {shreg[6:0], so};
        nbit++;
        if (nbit == 8) begin
          nbit = 0;
          if (exp_q.size() == 0) begin
            chk({4'h0, shreg}, 12'hxxx);
          end else begin
            chk({4'h0, shreg}, {4'h0, exp_q.pop_front()});
          end
        end
      end
    end
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    page_binary = 1'b0;
    mode3 = 1'b0;
    lat = 8'h02;
    void'($urandom(32'hbe53));
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    half();
    // page end crossing, standard pages, mode 0
    frame(sfcr_pkg::OP_READ_FASTEST, 12'h005, 10'h20e, 3, 0);
    // array end wrap, binary then standard pages, mode 3, slow array
    page_binary = 1'b1;
    mode3 = 1'b1;
    lat = 8'h09;
    frame(sfcr_pkg::OP_READ_LEGACY, 12'hfff, 10'h1fe, 3, 0);
    page_binary = 1'b0;
    frame(sfcr_pkg::OP_READ_LEGACY, 12'hfff, 10'h20f, 2, 0);
    // buffer read opcode is not served: no output at all
    frame(8'hd4, 12'h001, 10'h000, 0, 24);
    // deselect in mid byte ends the stream
    frame(sfcr_pkg::OP_READ_FASTEST, 12'h010, 10'h100, 1, 5);
    // random frames
    for (int k = 0; k < 4; k++) begin
      page_binary = 1'($urandom_range(1));
      mode3 = 1'($urandom_range(1));
      lat = 8'($urandom_range(12));
      frame(k[0] ? sfcr_pkg::OP_READ_LEGACY : sfcr_pkg::OP_READ_FASTEST,
            12'($urandom), 10'($urandom_range(page_binary ? 511 : 527)),
            3, 0);
    end
    // reset in mid frame aborts; cs still low starts nothing
    mode3 = 1'b0;
    sck = 1'b0;
    cs_b = 1'b0;
    half();
    shift({24'h0, sfcr_pkg::OP_READ_FASTEST}, 8);
    shift(32'h0, 10);
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({10'h0, so_oe, mem_rd}, 12'h000);
    rst_b = 1'b1;
    // a full fastest-read header must not start a stream
    shift({24'h0, sfcr_pkg::OP_READ_FASTEST}, 8);
    shift(32'h0, 40);
    chk({11'h0, so_oe}, 12'h000);
    sck = 1'b0;
    cs_b = 1'b1;
    half();
    frame(sfcr_pkg::OP_READ_FASTEST, 12'h123, 10'h000, 2, 0);
    end_sim();
  end
endmodule : tb_sfcr_core
